/* File: core/scr_map.vh */
`ifndef SCR_MAP_VH
`define SCR_MAP_VH
// ==========================================
// Command byte fields
`define SCR_CMD_W 8
`define SCR_CMD_RESET 8'h00
`define SCR_BIT_GUARD 7
`define SCR_BIT_RDWR 6
`define SCR_ADDR_HI 5
`define SCR_ADDR_LO 3
`define SCR_BIT_CONTINUOUS_RESULT_READ 2
// ==========================================
// Register addresses
`define SCR_A_CMD 3'h0
`define SCR_A_MODE 3'h1
`define SCR_A_CONF 3'h2
`define SCR_A_DATA 3'h3
`define SCR_A_ID 3'h4
`define SCR_A_IO 3'h5
`define SCR_A_OFFS 3'h6
`define SCR_A_FS 3'h7
// ==========================================
// Widths and counts
`define SCR_W8 5'h08
`define SCR_W16 5'h10
`define SCR_ONES_RESET 6'h20
`define SCR_CONTINUOUS_RESULT_READ_EXIT 8'h58
`define SCR_SYNC_RESET 2'h3
`endif

/* File: core/scr_sync.v */
`timescale 1ns/100ps
`include "scr_map.vh"
// Two-stage synchroniser for one pin
module scr_sync (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Pin and synchronised level
  input wire din,
  output reg dout
);
  reg meta;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Idle-high reset keeps select and clock deasserted, no false edge
      {meta, dout} <= `SCR_SYNC_RESET;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* File: core/scr_serial_if.v */
`timescale 1ns/100ps
`include "scr_map.vh"
module scr_serial_if #(
  parameter DATA_W = 24,
  parameter CAL_W = 24
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Serial link pins
  input wire sclk,
  input wire csn,
  input wire sdi,
  output reg sdo,
  // Register file side
  input wire [7:0] statusIn,
  input wire [15:0] modeIn,
  input wire [15:0] confIn,
  input wire [23:0] dataIn,
  input wire [7:0] idIn,
  input wire [7:0] ioIn,
  input wire [23:0] offsIn,
  input wire [23:0] fsIn,
  input wire resultReadyN,
  output reg [2:0] wrAddr,
  output reg [23:0] wrData,
  output reg wrStrobe,
  output reg rdStrobe,
  output reg partReset,
  output reg [7:0] commandByte,
  output reg contRead
);
  localparam ST_CMD = 2'h0;
  localparam ST_WR = 2'h1;
  localparam ST_RD = 2'h2;
  localparam ST_CONT = 2'h3;

  wire sclkS;
  wire csnS;
  wire sdiS;
  scr_sync uSyncClk (.clk(clk), .resetn(resetn), .din(sclk), .dout(sclkS));
  scr_sync uSyncCs (.clk(clk), .resetn(resetn), .din(csn), .dout(csnS));
  scr_sync uSyncDi (.clk(clk), .resetn(resetn), .din(sdi), .dout(sdiS));

  reg sclkQ;
  reg [1:0] state;
  reg [6:0] cmdShift;
  reg [2:0] cmdCnt;
  reg guardSeen;
  reg [4:0] bitCnt;
  reg [4:0] xferW;
  reg [23:0] shiftReg;
  reg [5:0] onesCnt;
  reg [7:0] watch;
  reg contArmed;
  wire rise = sclkS & ~sclkQ;
  wire fall = ~sclkS & sclkQ;
  wire active = ~csnS;

  // ==========================================
  // Register width and contents by address
  reg [4:0] selW;
  reg [23:0] selVal;
  always @* begin
    selW = `SCR_W8;
    selVal = 24'h000000;
    case (commandByte[`SCR_ADDR_HI:`SCR_ADDR_LO])
      `SCR_A_CMD: begin
        selW = `SCR_W8;
        selVal = {statusIn, 16'h0000};
      end
      `SCR_A_MODE: begin
        selW = `SCR_W16;
        selVal = {modeIn, 8'h00};
      end
      `SCR_A_CONF: begin
        selW = `SCR_W16;
        selVal = {confIn, 8'h00};
      end
      `SCR_A_DATA: begin
        selW = DATA_W[4:0];
        selVal = dataIn;
      end
      `SCR_A_ID: begin
        selW = `SCR_W8;
        selVal = {idIn, 16'h0000};
      end
      `SCR_A_IO: begin
        selW = `SCR_W8;
        selVal = {ioIn, 16'h0000};
      end
      `SCR_A_OFFS: begin
        selW = CAL_W[4:0];
        selVal = offsIn;
      end
      `SCR_A_FS: begin
        selW = CAL_W[4:0];
        selVal = fsIn;
      end
      default: begin
        selW = `SCR_W8;
        selVal = 24'h000000;
      end
    endcase
  end

  // ==========================================
  // Command interpreter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclkQ <= 1'b1;
      state <= ST_CMD;
      commandByte <= `SCR_CMD_RESET;
      cmdShift <= 7'h00;
      cmdCnt <= 3'h0;
      guardSeen <= 1'b0;
      bitCnt <= 5'h00;
      xferW <= 5'h00;
      shiftReg <= 24'h000000;
      onesCnt <= 6'h00;
      watch <= 8'h00;
      contArmed <= 1'b0;
      contRead <= 1'b0;
      sdo <= 1'b1;
      wrAddr <= 3'h0;
      wrData <= 24'h000000;
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      partReset <= 1'b0;
    end else begin
      sclkQ <= sclkS;
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b0;
      partReset <= 1'b0;
      if (contRead && active && rise) begin
        watch <= {watch[6:0], sdiS};
      end
      if (active && rise) begin
        if (sdiS) begin
          onesCnt <= onesCnt + 6'h01;
        end else begin
          onesCnt <= 6'h00;
        end
      end
      if (active && rise && sdiS && onesCnt == `SCR_ONES_RESET - 6'h01) begin
        // Lost sequence recovery, also live during continuous read
        partReset <= 1'b1;
        state <= ST_CMD;
        commandByte <= `SCR_CMD_RESET;
        guardSeen <= 1'b0;
        cmdCnt <= 3'h0;
        contRead <= 1'b0;
        contArmed <= 1'b0;
        onesCnt <= 6'h00;
        watch <= 8'h00;
        sdo <= 1'b1;
      end else if (contRead && active && rise && !resultReadyN &&
                   {watch[6:0], sdiS} == `SCR_CONTINUOUS_RESULT_READ_EXIT) begin
        // Exit is watched even while a result is shifting out
        contRead <= 1'b0;
        contArmed <= 1'b0;
        commandByte <= `SCR_CONTINUOUS_RESULT_READ_EXIT;
        bitCnt <= 5'h00;
        watch <= 8'h00;
        state <= ST_CMD;
      end else begin
        case (state)
          ST_CMD: begin
            sdo <= resultReadyN;
            if (active && rise) begin
              if (!guardSeen) begin
                // Stay on the guard bit until a zero arrives
                guardSeen <= ~sdiS;
                cmdCnt <= 3'h0;
              end else begin
                cmdShift <= {cmdShift[5:0], sdiS};
                cmdCnt <= cmdCnt + 3'h1;
                if (cmdCnt == 3'h6) begin
                  // Command register only ever loaded, never shifted out
                  commandByte <= {1'b0, cmdShift[5:0], sdiS};
                  guardSeen <= 1'b0;
                  bitCnt <= 5'h00;
                  contArmed <= 1'b0;
                  // Fresh data phase must not carry old bits into wrData
                  shiftReg <= 24'h000000;
                  if (cmdShift[`SCR_BIT_RDWR - 1] &&
                      cmdShift[`SCR_BIT_CONTINUOUS_RESULT_READ - 1] &&
                      cmdShift[`SCR_ADDR_HI - 1:`SCR_ADDR_LO - 1] ==
                      `SCR_A_DATA) begin
                    contRead <= 1'b1;
                    state <= ST_CONT;
                  end else if (cmdShift[`SCR_BIT_RDWR - 1]) begin
                    state <= ST_RD;
                  end else begin
                    state <= ST_WR;
                  end
                end
              end
            end
          end
          ST_WR: begin
            xferW <= selW;
            if (commandByte[`SCR_ADDR_HI:`SCR_ADDR_LO] == `SCR_A_CMD) begin
              state <= ST_CMD;
            end else if (active && rise) begin
              shiftReg <= {shiftReg[22:0], sdiS};
              bitCnt <= bitCnt + 5'h01;
              if (bitCnt + 5'h01 == selW) begin
                wrAddr <= commandByte[`SCR_ADDR_HI:`SCR_ADDR_LO];
                wrData <= {shiftReg[22:0], sdiS};
                wrStrobe <= 1'b1;
                state <= ST_CMD;
              end
            end
          end
          ST_RD: begin
            if (bitCnt == 5'h00 && !contArmed) begin
              shiftReg <= selVal;
              xferW <= selW;
              contArmed <= 1'b1;
              sdo <= selVal[23];
            end else if (active && fall && bitCnt != 5'h00) begin
              sdo <= shiftReg[23];
            end else if (active && rise) begin
              shiftReg <= {shiftReg[22:0], 1'b0};
              bitCnt <= bitCnt + 5'h01;
              if (bitCnt + 5'h01 == xferW) begin
                contArmed <= 1'b0;
                rdStrobe <= 1'b1;
                if (commandByte[`SCR_BIT_CONTINUOUS_RESULT_READ] &&
                    commandByte[`SCR_ADDR_HI:`SCR_ADDR_LO] == `SCR_A_DATA) begin
                  contRead <= 1'b1;
                  state <= ST_CONT;
                end else begin
                  state <= ST_CMD;
                end
              end
            end
          end
          ST_CONT: begin
            sdo <= resultReadyN;
            if (!resultReadyN && active && fall) begin
              // New result: shift it out with no command byte
              shiftReg <= dataIn;
              xferW <= DATA_W[4:0];
              bitCnt <= 5'h00;
              contArmed <= 1'b1;
              sdo <= dataIn[23];
              state <= ST_RD;
            end
          end
          default: begin
            state <= ST_CMD;
          end
        endcase
      end
    end
  end
endmodule

/* File: tb/scr_checker.sv */
`timescale 1ns/100ps
module scr_checker (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Watched outputs
  input wire [2:0] wrAddr,
  input wire wrStrobe,
  input wire rdStrobe,
  input wire partReset,
  input wire [7:0] commandByte,
  input wire contRead
);
  // ====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  guard_clear_a: assert property (!commandByte[7])
    else $error("guard bit kept in command byte");
  wr_pulse_a: assert property (wrStrobe |=> !wrStrobe)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property (rdStrobe |=> !rdStrobe)
    else $error("read strobe longer than one cycle");
  one_strobe_a: assert property (!(wrStrobe && rdStrobe))
    else $error("read and write strobes together");
  wr_target_a: assert property (wrStrobe |-> !commandByte[6] &&
    wrAddr == commandByte[5:3] && wrAddr != 3'h0)
    else $error("write to wrong register or direction");
  rd_dir_a: assert property (rdStrobe |-> commandByte[6])
    else $error("read done under a write command");
  continuous_result_read_entry_a: assert property ($rose(contRead) |->
    commandByte[5:2] == 4'h7)
    else $error("continuous read without data address");
  part_reset_a: assert property (partReset |-> ##[1:4]
    (commandByte == 8'h00 && !contRead))
    else $error("ones reset did not clear state");
endmodule

/* File: tb/scr_host.sv */
`timescale 1ns/100ps
module scr_host (
  // Link outputs
  output logic sclk,
  output logic csn,
  output logic sdi,
  // Link input
  input wire sdo
);
  // ====
  // Host link driver
  initial begin
    sclk = 1'b1;
    csn = 1'b1;
    sdi = 1'b0;
  end
  // Clock stands high between frames
  task automatic xfer(input logic [31:0] v, input int n,
    output logic [31:0] r);
    r = '0;
    csn = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = v[i];
      #40;
      sclk = 1'b1;
      r = {r[30:0], sdo};
      #40;
    end
    sdi = ~sdi;
    #40;
  endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin errTotal++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
  // ====
  // Signals
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic resultReadyN = 1'b1;
  logic sclk, csn, sdi, sdo, wrStrobe, rdStrobe, partReset, contRead;
  logic [7:0] statusIn, idIn, ioIn, commandByte;
  logic [15:0] modeIn, confIn;
  logic [23:0] dataIn, offsIn, fsIn, wrData, gotData;
  logic [2:0] wrAddr, gotAddr;
  logic [23:0] rv [8];
  logic [31:0] r, v;
  int errTotal = 0, testsRun = 0, wrN = 0, rdN = 0, partN = 0;
  assign statusIn = rv[0][7:0];
  assign modeIn = rv[1][15:0];
  assign confIn = rv[2][15:0];
  assign dataIn = rv[3];
  assign idIn = rv[4][7:0];
  assign ioIn = rv[5][7:0];
  assign offsIn = rv[6];
  assign fsIn = rv[7];
  scr_host i_scr_host(.sclk, .csn, .sdi, .sdo);
  scr_serial_if i_scr_serial_if(.clk, .resetn, .sclk, .csn, .sdi, .sdo,
    .statusIn, .modeIn, .confIn, .dataIn, .idIn, .ioIn, .offsIn, .fsIn,
    .resultReadyN, .wrAddr, .wrData, .wrStrobe, .rdStrobe, .partReset,
    .commandByte, .contRead);
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    if (wrStrobe) begin
      wrN++;
      gotAddr = wrAddr;
      gotData = wrData;
    end
    if (rdStrobe) rdN++;
    if (partReset) partN++;
  end
  // ====
  // Expectations
  function automatic int wid(input int a);
    return (a == 1 || a == 2) ? 16 : (a == 3 || a > 5) ? 24 : 8;
  endfunction
  function automatic logic [23:0] msk(input int a);
    return 24'hFFFFFF >> (24 - wid(a));
  endfunction
  task automatic cmd(input logic [7:0] c);
    i_scr_host.xfer({24'h000000, c}, 8, r);
  endtask
  task stopTest;
    if (errTotal == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #500000;
    errTotal++;
    stopTest;
  end
  // ====
  // Scenarios
  initial begin
    void'($urandom(32'h3BED));
    for (int a = 0; a < 8; a++) rv[a] = $urandom & msk(a);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    `CHK({contRead, sdo, commandByte}, 10'h100)
    for (int a = 1; a < 8; a++) if (a != 3 && a != 4) begin
      v = $urandom & msk(a);
      i_scr_host.xfer('1, $urandom_range(3, 0), r);
      cmd(8'(a * 8));
      i_scr_host.xfer(v, wid(a), r);
      `CHK({gotAddr, gotData}, {3'(a), v[23:0]})
      `CHK(commandByte, 8'(a * 8))
    end
    `CHK(wrN, 5)
    for (int a = 0; a < 8; a++) begin
      cmd(8'(8'h40 + a * 8));
      i_scr_host.xfer(0, wid(a), r);
      `CHK(r[23:0], rv[a])
    end
    `CHK(rdN, 8)
    for (int k = 0; k < 2; k++) begin
      resultReadyN = k;
      repeat (4) @(negedge clk);
      `CHK(sdo, resultReadyN)
    end
    cmd(8'h5C);
    `CHK(contRead, 1'b1)
    repeat (2) begin
      rv[3] = $urandom;
      resultReadyN = 1'b0;
      repeat (4) @(negedge clk);
      i_scr_host.xfer(0, 24, r);
      `CHK(r[23:0], rv[3])
      resultReadyN = 1'b1;
      repeat (4) @(negedge clk);
    end
    resultReadyN = 1'b0;
    cmd(8'h58);
    `CHK(contRead, 1'b0)
    resultReadyN = 1'b1;
    cmd(8'h5C);
    i_scr_host.xfer('1, 32, r);
    repeat (8) @(negedge clk);
    `CHK({partN, contRead, commandByte}, {32'h1, 9'h000})
    stopTest;
  end
endmodule
bind scr_serial_if scr_checker i_scr_checker(.clk, .resetn, .wrAddr,
  .wrStrobe, .rdStrobe, .partReset, .commandByte, .contRead);
